// File: usbc_map.svh
// Purpose: offsets, codes, field positions, reset values, timing figures
// Assumes: 10 MHz reference clock
// Notes:   definitions only
`ifndef USBC_MAP_SVH
`define USBC_MAP_SVH
// ----------------------------------------
// APB byte offsets
// ----------------------------------------
`define USBC_A_CMD 8'h00
`define USBC_A_DATA 8'h04
`define USBC_A_STAT 8'h08
// ----------------------------------------
// Command codes
// ----------------------------------------
`define USBC_C_ADDR_W 8'hb6
`define USBC_C_ADDR_R 8'hb7
`define USBC_C_MODE_W 8'hb8
`define USBC_C_MODE_R 8'hb9
`define USBC_C_HW_W 8'hba
`define USBC_C_HW_R 8'hbb
`define USBC_C_IE_W 8'hc2
`define USBC_C_IE_R 8'hc3
`define USBC_C_DEVRST 8'hf6
`define USBC_C_ACKSET 8'hf4
`define USBC_C_DMAF_W 8'hb2
`define USBC_C_DMAF_R 8'hb3
`define USBC_C_DMAC_W 8'hf0
`define USBC_C_DMAC_R 8'hf1
`define USBC_C_DMAN_W 8'hf2
`define USBC_C_DMAN_R 8'hf3
`define USBC_C_UNLOCK 8'hb0
`define USBC_C_FRAME 8'hb4
`define USBC_C_CHIPID 8'hb5
`define USBC_C_INT_R 8'hc0
`define USBC_UNLOCK_KEY 16'haa37
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define USBC_MODE_SUSPEND_REQUEST 5
`define USBC_MODE_INTENA 3
`define USBC_HW_CLOCKS_KEEP_RUNNING 12
`define USBC_HW_WAKE_ON_SELECT_ENABLE 3
`define USBC_HW_RST 16'h2300
`define USBC_IR_SUSP 0
`define USBC_IR_RES 1
`define USBC_IR_BUSST 2
`define USBC_ECR0_OUT_RST 8'h83
`define USBC_ECR0_IN_RST 8'hc3
`define USBC_ECR_ISO 4
`define USBC_BUF_SMALL 11'h040
`define USBC_BUF_ISO 11'h3ff
// ----------------------------------------
// Timing figures
// ----------------------------------------
`define USBC_CLK_MHZ 10
`define USBC_T_IDLE_US 3000
`define USBC_T_STOP_US 2000
`define USBC_T_GRES_US 20000
`define USBC_T_WAKE_MAX_US 15000
`define USBC_T_KDRV_US 10000
`define USBC_T_OSC_US 1000
`endif

// File: usbc_pkg.sv
// Purpose: shared types of the command and suspend controller
// Assumes: nothing
// Notes:   constants live in usbc_map.svh
package usbc_pkg;
   typedef enum logic [1:0]
   {
      USBC_AWAKE = 2'b00,
      USBC_SUSP_WAIT = 2'b01,
      USBC_SUSPENDED = 2'b10,
      USBC_WAKE = 2'b11
   } usbc_state_t;
endpackage : usbc_pkg

// File: usbc_ctrl.sv
// Purpose: command interpreter and suspend/resume control over APB
// Assumes: pins are asynchronous; APB on ref_clk_in
// Notes:   FIFO memory and DMA engine sit outside this block
`include "usbc_map.svh"

// What this block does
// (RQ1) Suspend seen after idle beyond 3 ms
// (RQ2) Suspend edge sets flag, interrupt if enabled
// (RQ3) Live bus state readable as bus_idle_status
// (RQ4) Firmware clears clocks_keep_running before suspend
// (RQ5) suspend_request falling edge enters suspend
// (RQ6) Suspend output, clocks stop 2 ms later
// (RQ7) Wake on 20 ms K, wake_input, select
// (RQ8) Select wake needs enable and bus supply
// (RQ9) Clocks stable, suspend off, resume flag set
// (RQ10) Normal operation within 15 ms of wake
// (RQ11) Remote wake drives K for 10 ms
// (RQ12) Registers locked after wake until unlock B0h key AA37h
// (RQ13) Select high: byte is command, run immediately
// (RQ14) Select low: data phase, low byte first
// (RQ15) Endpoint configuration codes 20h-2Fh, 30h-3Fh
// (RQ16) Address, mode, hardware config, enable, reset codes
// (RQ17) Buffer writes 01h-0Fh with size limits
// (RQ18) Buffer reads 10h, 12h-1Fh; 00h, 11h illegal
// (RQ19) Stall 40h-4Fh, unstall 80h-8Fh, no data
// (RQ20) Status 5xh, image Dxh, setup ack F4h
// (RQ21) Validate IN only, clear OUT only
// (RQ22) DMA registers move two bytes each
// (RQ23) Error, frame, chip id, interrupt reads
// (RQ24) suspend_request is mode bit 5
// (RQ25) Last command stays target of data phase
// (RQ26) Locked writes leave registers unchanged
module usbc_ctrl
   import usbc_pkg::*;
#(
   parameter logic [17:0] IDLE_CYC = 18'(`USBC_T_IDLE_US * `USBC_CLK_MHZ),
   parameter logic [17:0] STOP_CYC = 18'(`USBC_T_STOP_US * `USBC_CLK_MHZ),
   parameter logic [17:0] GRES_CYC = 18'(`USBC_T_GRES_US * `USBC_CLK_MHZ),
   parameter logic [17:0] KDRV_CYC = 18'(`USBC_T_KDRV_US * `USBC_CLK_MHZ),
   parameter logic [17:0] OSC_CYC = 18'(`USBC_T_OSC_US * `USBC_CLK_MHZ),
   parameter logic [17:0] WAKE_MAX_CYC =
      18'(`USBC_T_WAKE_MAX_US * `USBC_CLK_MHZ),
   parameter logic [15:0] CHIP_ID = 16'h0a5a  // Arbitrary value
)
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Pins, asynchronous
   input wire logic bus_idle_in,
   input wire logic bus_k_in,
   input wire logic wake_input_in,
   input wire logic chip_select_n_in,
   input wire logic vbus_present_in,
   // Endpoint side, same clock
   input wire logic [7:0] ext_rd_data_in,
   output logic [7:0] cmd_out,
   output logic [9:0] byte_idx_out,
   output logic fifo_wr_out,
   output logic fifo_rd_out,
   output logic [7:0] fifo_data_out,
   output logic validate_out,
   output logic clear_buf_out,
   output logic ack_setup_out,
   output logic dev_reset_out,
   output logic [15:0] stall_out,
   output logic [7:0] dev_addr_out,
   // Power control
   output logic suspend_out,
   output logic clocks_run_out,
   output logic k_drive_out,
   output logic irq_out
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   wire idle_s = sync2_r[0];
   wire k_s = sync2_r[1];
   wire wake_s = sync2_r[2];
   wire csn_s = sync2_r[3];
   wire vbus_s = sync2_r[4];

   // Two flops per pin; only sync2_r is read by logic
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         sync1_r <= 5'h08;
         sync2_r <= 5'h08;
      end
      else
      begin
         sync1_r <= {vbus_present_in, chip_select_n_in, wake_input_in,
                     bus_k_in, bus_idle_in};
         sync2_r <= sync1_r;
      end

   // ----------------------------------------
   // State and storage
   // ----------------------------------------
   usbc_state_t st_r;
   logic [7:0] cmd_r;
   logic [9:0] cnt_r;
   logic [7:0] ecr_r [16];
   logic [7:0] addr_r;
   logic [7:0] mode_r;
   logic [15:0] hwcfg_r;
   logic [31:0] ie_r;
   logic [15:0] dmaf_r;
   logic [15:0] dmac_r;
   logic [15:0] dman_r;
   logic lock_r;
   logic key_lo_r;
   logic susp_flag_r;
   logic res_flag_r;
   logic bus_susp_r;
   logic [17:0] idle_cnt_r;
   logic [17:0] kres_cnt_r;
   logic [17:0] tmr_r;
   logic [17:0] kdrv_cnt_r;
   logic [7:0] rd_byte;
   logic [31:0] reg_word;
   logic [10:0] nb;
   logic ext_sel;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // First access cycle only; pready follows one edge later
   wire acc = psel_in & penable_in & ~pready_out;
   wire a_cmd = paddr_in == `USBC_A_CMD;
   wire a_data = paddr_in == `USBC_A_DATA;
   wire a_stat = paddr_in == `USBC_A_STAT;
   wire cwr = acc & pwrite_in & a_cmd;
   wire dwr = acc & pwrite_in & a_data;
   wire drd = acc & ~pwrite_in & a_data;
   wire [7:0] wb = pwdata_in[7:0];
   wire [3:0] hi = cmd_r[7:4];
   wire [3:0] ep = cmd_r[3:0];
   wire [3:0] new_hi = wb[7:4];
   wire [3:0] new_ep = wb[3:0];
   wire in_rng = {1'b0, cnt_r} < nb;
   // Register writes only while unlocked
   wire rwr = dwr & ~lock_r & in_rng;  // RQ26
   wire [1:0] bi = cnt_r[1:0];
   wire soft_rst = cwr & (wb == `USBC_C_DEVRST);  // RQ16
   wire buf_w = (hi == 4'h0) & (ep != 4'h0);  // RQ17
   wire buf_r = (hi == 4'h1) & (ep != 4'h1);  // RQ18
   wire [10:0] buf_lim = (ep <= 4'h1 || !ecr_r[ep][`USBC_ECR_ISO]) ?
      `USBC_BUF_SMALL : `USBC_BUF_ISO;
   wire suspend_request_fall = rwr & (cmd_r == `USBC_C_MODE_W) & (bi == 2'h0) &
      mode_r[`USBC_MODE_SUSPEND_REQUEST] & ~wb[`USBC_MODE_SUSPEND_REQUEST];  // RQ5 RQ24
   wire int_rd_clr = drd & (cmd_r == `USBC_C_INT_R) & (cnt_r == 10'h0);
   wire susp_rise = ~bus_susp_r & idle_s & (idle_cnt_r == IDLE_CYC);
   wire wk_glob = kres_cnt_r == GRES_CYC;  // RQ7
   wire wk_cs = ~csn_s & hwcfg_r[`USBC_HW_WAKE_ON_SELECT_ENABLE] & vbus_s;  // RQ8
   wire wk_remote = wake_s | wk_cs;  // RQ7
   wire asleep = (st_r == USBC_SUSP_WAIT) | (st_r == USBC_SUSPENDED);
   wire wake_go = asleep & (wk_glob | wk_remote);
   wire [31:0] int_word = {29'h0, bus_susp_r, res_flag_r, susp_flag_r};
   wire irq_nxt = mode_r[`USBC_MODE_INTENA] &
      ((susp_flag_r & ie_r[`USBC_IR_SUSP]) |
       (res_flag_r & ie_r[`USBC_IR_RES]));  // RQ2 RQ9

   // ----------------------------------------
   // Data phase read selection and sizes
   // ----------------------------------------
   always_comb
   begin
      reg_word = 32'h0;
      nb = 11'h0;
      ext_sel = 1'b0;
      case (cmd_r)  // RQ25
         `USBC_C_ADDR_R: begin reg_word = {24'h0, addr_r}; nb = 11'h1; end
         `USBC_C_ADDR_W: nb = 11'h1;
         `USBC_C_MODE_R: begin reg_word = {24'h0, mode_r}; nb = 11'h1; end
         `USBC_C_MODE_W: nb = 11'h1;
         `USBC_C_HW_R: begin reg_word = {16'h0, hwcfg_r}; nb = 11'h2; end
         `USBC_C_HW_W: nb = 11'h2;
         `USBC_C_IE_R: begin reg_word = ie_r; nb = 11'h4; end
         `USBC_C_IE_W: nb = 11'h4;
         `USBC_C_DMAF_R: begin reg_word = {16'h0, dmaf_r}; nb = 11'h2; end
         `USBC_C_DMAC_R: begin reg_word = {16'h0, dmac_r}; nb = 11'h2; end
         `USBC_C_DMAN_R: begin reg_word = {16'h0, dman_r}; nb = 11'h2; end
         `USBC_C_DMAF_W, `USBC_C_DMAC_W, `USBC_C_DMAN_W: nb = 11'h2;  // RQ22
         `USBC_C_UNLOCK: nb = 11'h2;
         `USBC_C_CHIPID: begin reg_word = {16'h0, CHIP_ID}; nb = 11'h2; end
         `USBC_C_FRAME: begin ext_sel = 1'b1; nb = 11'h2; end  // RQ23
         `USBC_C_INT_R: begin reg_word = int_word; nb = 11'h4; end  // RQ3
         default:
            case (hi)
               4'h2: nb = 11'h1;  // RQ15
               4'h3: begin reg_word = {24'h0, ecr_r[ep]}; nb = 11'h1; end
               4'h5, 4'ha, 4'hd: begin ext_sel = 1'b1; nb = 11'h1; end  // RQ20
               4'h0: nb = buf_w ? buf_lim : 11'h0;
               4'h1: begin ext_sel = buf_r; nb = buf_r ? buf_lim : 11'h0; end
               default: nb = 11'h0;
            endcase
      endcase
   end

   // Bytes past the register width read as zero
   assign rd_byte = !in_rng ? 8'h0 :
      ext_sel ? ext_rd_data_in : reg_word[{bi, 3'b000} +: 8];  // RQ14

   // ----------------------------------------
   // APB answer, one wait state
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= acc;
         pslverr_out <= acc & ~(a_cmd | a_data | a_stat);
         prdata_out <= !acc || pwrite_in ? 32'h0 :
            a_cmd ? {24'h0, cmd_r} :
            a_data ? {24'h0, rd_byte} :
            a_stat ? {26'h0, lock_r, bus_susp_r, suspend_out,
                      clocks_run_out, st_r} : 32'h0;
      end

   // ----------------------------------------
   // Command latch, byte index, endpoint strobes
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         cmd_r <= 8'h0;
         cnt_r <= 10'h0;
         fifo_wr_out <= 1'b0;
         fifo_rd_out <= 1'b0;
         fifo_data_out <= 8'h0;
         validate_out <= 1'b0;
         clear_buf_out <= 1'b0;
         ack_setup_out <= 1'b0;
         dev_reset_out <= 1'b0;
         stall_out <= 16'h0;
      end
      else
      begin
         if (cwr)
         begin
            cmd_r <= wb;  // RQ13 RQ25
            cnt_r <= 10'h0;
         end
         else if ((dwr | drd) && cnt_r != 10'h3ff)
            cnt_r <= cnt_r + 10'h1;  // RQ14
         fifo_wr_out <= dwr & buf_w & in_rng;  // RQ17
         fifo_rd_out <= drd & buf_r & in_rng;  // RQ18
         if (dwr)
            fifo_data_out <= wb;
         // No-data commands act on the command write itself
         validate_out <= cwr & (new_hi == 4'h6) & (new_ep != 4'h0);  // RQ21
         clear_buf_out <= cwr & (new_hi == 4'h7) & (new_ep != 4'h1);  // RQ21
         ack_setup_out <= cwr & (wb == `USBC_C_ACKSET);  // RQ20
         dev_reset_out <= soft_rst;
         if (soft_rst)
            stall_out <= 16'h0;
         else if (cwr && new_hi == 4'h4)
            stall_out[new_ep] <= 1'b1;  // RQ19
         else if (cwr && new_hi == 4'h8)
            stall_out[new_ep] <= 1'b0;  // RQ19
      end

   assign cmd_out = cmd_r;
   assign byte_idx_out = cnt_r;
   assign dev_addr_out = addr_r;

   // ----------------------------------------
   // Endpoint configuration array
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_ecr
         localparam logic [7:0] RST = (g == 0) ? `USBC_ECR0_OUT_RST :
            (g == 1) ? `USBC_ECR0_IN_RST : 8'h00;
         always_ff @(posedge ref_clk_in or negedge rstn_in)
            if (!rstn_in)
               ecr_r[g] <= RST;
            else if (soft_rst)
               ecr_r[g] <= RST;
            else if (rwr && hi == 4'h2 && ep == 4'(g))
               ecr_r[g] <= wb;  // RQ15
      end
   endgenerate

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         addr_r <= 8'h0;
         mode_r <= 8'h0;
         hwcfg_r <= `USBC_HW_RST;
         ie_r <= 32'h0;
         dmaf_r <= 16'h0;
         dmac_r <= 16'h0;
         dman_r <= 16'h0;
      end
      else if (soft_rst)
      begin
         addr_r <= 8'h0;
         mode_r <= 8'h0;
         hwcfg_r <= `USBC_HW_RST;
         ie_r <= 32'h0;
         dmaf_r <= 16'h0;
         dmac_r <= 16'h0;
         dman_r <= 16'h0;
      end
      else if (rwr)
         case (cmd_r)  // RQ16 RQ22
            `USBC_C_ADDR_W: addr_r <= wb;
            `USBC_C_MODE_W: mode_r <= wb;
            `USBC_C_HW_W: hwcfg_r[{bi[0], 3'b000} +: 8] <= wb;
            `USBC_C_IE_W: ie_r[{bi, 3'b000} +: 8] <= wb;
            `USBC_C_DMAF_W: dmaf_r[{bi[0], 3'b000} +: 8] <= wb;
            `USBC_C_DMAC_W: dmac_r[{bi[0], 3'b000} +: 8] <= wb;
            `USBC_C_DMAN_W: dman_r[{bi[0], 3'b000} +: 8] <= wb;
            default: ;
         endcase

   // ----------------------------------------
   // Unlock sequence, low key byte first
   // ----------------------------------------
   // Key bytes are selected from a constant, not a literal
   localparam logic [15:0] UNL_KEY = `USBC_UNLOCK_KEY;
   wire unl = dwr & (cmd_r == `USBC_C_UNLOCK);
   wire wake_done = (st_r == USBC_WAKE) & (tmr_r == OSC_CYC - 18'h1);

   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         lock_r <= 1'b0;
         key_lo_r <= 1'b0;
      end
      else
      begin
         if (unl && cnt_r == 10'h0)
            key_lo_r <= wb == UNL_KEY[7:0];
         if (wake_done)
            lock_r <= 1'b1;  // RQ12
         else if (unl && cnt_r == 10'h1 && key_lo_r &&
                  wb == UNL_KEY[15:8])
            lock_r <= 1'b0;  // RQ12
      end

   // ----------------------------------------
   // Bus idle detection and event flags
   // ----------------------------------------
   // Set wins over the read that clears
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         idle_cnt_r <= 18'h0;
         bus_susp_r <= 1'b0;
         susp_flag_r <= 1'b0;
         res_flag_r <= 1'b0;
         irq_out <= 1'b0;
      end
      else
      begin
         idle_cnt_r <= !idle_s ? 18'h0 :
            (idle_cnt_r == IDLE_CYC) ? idle_cnt_r : idle_cnt_r + 18'h1;
         if (!idle_s)
            bus_susp_r <= 1'b0;  // RQ3
         else if (susp_rise)
            bus_susp_r <= 1'b1;  // RQ1
         susp_flag_r <= susp_rise | (susp_flag_r & ~int_rd_clr);  // RQ2
         res_flag_r <= wake_done | (res_flag_r & ~int_rd_clr);  // RQ9
         irq_out <= irq_nxt;
      end

   // ----------------------------------------
   // Suspend and wake sequencer
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         st_r <= USBC_AWAKE;
         tmr_r <= 18'h0;
         suspend_out <= 1'b0;
         clocks_run_out <= 1'b1;
      end
      else
         case (st_r)
            USBC_AWAKE:
               if (suspend_request_fall)
               begin
                  st_r <= USBC_SUSP_WAIT;  // RQ5
                  suspend_out <= 1'b1;  // RQ6
                  tmr_r <= 18'h0;
               end
            USBC_SUSP_WAIT:
               if (wake_go)
               begin
                  st_r <= USBC_WAKE;
                  tmr_r <= 18'h0;
               end
               else if (tmr_r == STOP_CYC - 18'h1)
               begin
                  st_r <= USBC_SUSPENDED;
                  // Clocks stay on if firmware kept them running
                  clocks_run_out <= hwcfg_r[`USBC_HW_CLOCKS_KEEP_RUNNING];  // RQ6 RQ4
               end
               else
                  tmr_r <= tmr_r + 18'h1;
            USBC_SUSPENDED:
               if (wake_go)
               begin
                  st_r <= USBC_WAKE;  // RQ7
                  tmr_r <= 18'h0;
                  clocks_run_out <= 1'b1;  // RQ9
               end
            USBC_WAKE:
               if (wake_done)
               begin
                  st_r <= USBC_AWAKE;  // RQ10
                  suspend_out <= 1'b0;  // RQ9
               end
               else
                  tmr_r <= tmr_r + 18'h1;
            default:
               st_r <= USBC_AWAKE;
         endcase

   // ----------------------------------------
   // Global resume timer and remote K drive
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         kres_cnt_r <= 18'h0;
         kdrv_cnt_r <= 18'h0;
         k_drive_out <= 1'b0;
      end
      else
      begin
         kres_cnt_r <= !(k_s && asleep) ? 18'h0 :
            wk_glob ? kres_cnt_r : kres_cnt_r + 18'h1;  // RQ7
         // Host resume takes precedence; no K of our own then
         if (wake_go && !wk_glob)
         begin
            kdrv_cnt_r <= KDRV_CYC - 18'h1;  // RQ11
            k_drive_out <= 1'b1;
         end
         else if (kdrv_cnt_r != 18'h0)
            kdrv_cnt_r <= kdrv_cnt_r - 18'h1;
         else
            k_drive_out <= 1'b0;
      end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_sleep_start;
      (st_r == USBC_AWAKE) && suspend_request_fall;
   endsequence
   sequence s_sleeping;
      (st_r == USBC_SUSP_WAIT) && suspend_out;
   endsequence

   idle_detect_a: assert property ($rose(bus_susp_r) |->  // RQ1
      $past(idle_cnt_r) == IDLE_CYC && $past(idle_s))
      else $error("suspend seen before idle time");
   susp_flag_a: assert property ($rose(bus_susp_r) |-> susp_flag_r) // RQ2
      else $error("suspend flag not set");
   irq_gate_a: assert property (irq_out |-> // RQ2
      $past(mode_r[`USBC_MODE_INTENA]) && ($past(ie_r[1:0]) != 2'h0))
      else $error("interrupt without enable");
   sleep_entry_a: assert property (s_sleep_start |=> s_sleeping) // RQ5
      else $error("suspend not entered");
   clk_stop_a: assert property ($fell(clocks_run_out) |-> // RQ6
      $past(tmr_r) == STOP_CYC - 18'h1 && $past(st_r) == USBC_SUSP_WAIT)
      else $error("clock stop timing wrong");
   cs_gate_a: assert property ((st_r == USBC_SUSPENDED) && !wake_s &&
      !wk_glob && !(hwcfg_r[`USBC_HW_WAKE_ON_SELECT_ENABLE] && vbus_s) |=> // RQ8
      st_r == USBC_SUSPENDED)
      else $error("select wake while disabled");
   wake_end_a: assert property ($fell(suspend_out) |-> // RQ9
      res_flag_r && lock_r && st_r == USBC_AWAKE)
      else $error("wake end incomplete");
   wake_bound_a: assert property ((st_r == USBC_WAKE) |-> // RQ10
      tmr_r < WAKE_MAX_CYC)
      else $error("wake too long");
   kdrive_len_a: assert property ($rose(k_drive_out) |-> // RQ11
      k_drive_out[*8] ##0 kdrv_cnt_r == KDRV_CYC - 18'h8)
      else $error("remote K too short");
   lock_hold_a: assert property (lock_r && dwr && // RQ26
      cmd_r == `USBC_C_MODE_W |=> mode_r == $past(mode_r))
      else $error("locked write changed mode");

endmodule : usbc_ctrl

// File: usbc_bus_model.sv
// Purpose: USB bus side and endpoint memory facing the controller
// Assumes: one clock; pins change just after the rising edge
// Notes:   LAG sets how slowly the idle line follows its request; K follows at once
module usbc_bus_model
#(
   parameter int LAG = 2
)
(
   // Clock and request
   input wire logic clk_in,
   input wire logic idle_req_in,
   input wire logic k_req_in,
   input wire logic [9:0] byte_idx_in,
   // Bus pins and endpoint data
   output logic bus_idle_out,
   output logic bus_k_out,
   output logic [7:0] rd_data_out
);
   logic [7:0] hist_r = 8'h00;
   // Idle line lags the request, like a slow hub
   always_ff @(posedge clk_in)
   begin
      hist_r <= {hist_r[6:0], idle_req_in};
   end
   assign bus_idle_out = hist_r[LAG];
   // Host K level follows the bench request
   assign bus_k_out = k_req_in;
   // Pattern moves with the index so stale bytes show
   assign rd_data_out = byte_idx_in[7:0] ^ 8'h5a;
endmodule : usbc_bus_model

// File: testbench.sv
// Purpose: self-checking bench for the command and suspend block
// Assumes: shortened counts set at the instance
// Notes:   APB master tasks hold each request until pready
`include "usbc_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, r;
   logic idle_req = 1'b0, wake = 1'b0, csn = 1'b1, vbus = 1'b1;
   logic k_req = 1'b0;
   logic irq, vld, fwr, dvrst;
   logic e;
   logic [31:0] prdata;
   logic pready, pslverr, b_idle, b_k, susp, clocks_keep_running, kdrv;
   logic [7:0] ext_rd, dev_addr, cmdo;
   logic [9:0] bidx;
   logic [15:0] stall;
   int failures = 0;
   int checks_done = 0;
   int n_vld = 0, n_fwr = 0, n_rst = 0;
   always #50 clk = ~clk;
   usbc_ctrl #(.IDLE_CYC(18'd20), .STOP_CYC(18'd10), .GRES_CYC(18'd20),
      .KDRV_CYC(18'd12), .OSC_CYC(18'd5), .WAKE_MAX_CYC(18'd50)) i_dut (
      .ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .bus_idle_in(b_idle), .bus_k_in(b_k),
      .wake_input_in(wake), .chip_select_n_in(csn),
      .vbus_present_in(vbus), .ext_rd_data_in(ext_rd), .cmd_out(cmdo),
      .byte_idx_out(bidx), .fifo_wr_out(fwr), .fifo_rd_out(),
      .fifo_data_out(), .validate_out(vld), .clear_buf_out(),
      .ack_setup_out(), .dev_reset_out(dvrst), .stall_out(stall),
      .dev_addr_out(dev_addr), .suspend_out(susp),
      .clocks_run_out(clocks_keep_running), .k_drive_out(kdrv), .irq_out(irq));
   usbc_bus_model #(.LAG(2)) i_bus (.clk_in(clk), .idle_req_in(idle_req),
      .k_req_in(k_req), .byte_idx_in(bidx), .bus_idle_out(b_idle),
      .bus_k_out(b_k), .rd_data_out(ext_rd));
   // Strobes stand one cycle; count them where they stand
   always @(posedge clk)
   begin
      n_vld <= n_vld + int'(vld);
      n_fwr <= n_fwr + int'(fwr);
      n_rst <= n_rst + int'(dvrst);
   end
   // ----------------------------------------
   // Report and compare
   // ----------------------------------------
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // ----------------------------------------
   // APB master, request held until pready
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         failures++;
         stop_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, r, e);
      chk(32'(e), 32'h0);
   endtask : wr
   // Bounded wait on a power output: 0 suspend, 1 clocks, 2 K drive
   task automatic wait_for(input int w, input logic v, input int lim);
      int n;
      n = 0;
      while ((w == 0 ? susp : w == 1 ? clocks_keep_running : kdrv) !== v && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(w == 0 ? susp : w == 1 ? clocks_keep_running : kdrv), 32'(v));
      if (n == lim && failures > 0)
         stop_test;
   endtask : wait_for
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      chk(32'({susp, clocks_keep_running}), 32'h1);
      rstn <= 1'b1;
      @(posedge clk);
      wr(`USBC_A_CMD, `USBC_C_ADDR_W);
      wr(`USBC_A_DATA, 8'h85);
      chk(32'(dev_addr), 32'h85);
      wr(`USBC_A_CMD, `USBC_C_ADDR_R);
      apb(1'b0, `USBC_A_DATA, 8'h00, r, e);
      chk(r & 32'hff, 32'h85);
      wr(`USBC_A_CMD, 8'h43);
      chk(32'(stall), 32'h8);
      wr(`USBC_A_CMD, 8'h83);
      chk(32'(stall), 32'h0);
      apb(1'b0, `USBC_A_CMD, 8'h00, r, e);
      chk(r & 32'hff, 32'h83);
      apb(1'b0, 8'h0c, 8'h00, r, e);
      chk(32'(e), 32'h1);
      // Validate refused on OUT 60h; buffer byte strobed
      wr(`USBC_A_CMD, 8'h60);
      wr(`USBC_A_CMD, 8'h62);
      chk(32'(n_vld), 32'h1);
      wr(`USBC_A_CMD, 8'h01);
      wr(`USBC_A_DATA, 8'h3c);
      chk(32'(n_fwr), 32'h1);
      chk(32'(cmdo), 32'h01);
      // Idle bus, then firmware suspend entry
      idle_req <= 1'b1;
      repeat (40) @(posedge clk);
      apb(1'b0, `USBC_A_STAT, 8'h00, r, e);
      chk(r & 32'h10, 32'h10);
      wr(`USBC_A_CMD, `USBC_C_HW_W);
      wr(`USBC_A_DATA, 8'h08);
      wr(`USBC_A_DATA, 8'h00);
      wr(`USBC_A_CMD, `USBC_C_IE_W);
      wr(`USBC_A_DATA, 8'h02);
      wr(`USBC_A_CMD, `USBC_C_MODE_W);
      wr(`USBC_A_DATA, 8'h28);
      chk(32'(susp), 32'h0);
      chk(32'(irq), 32'h0);
      wr(`USBC_A_CMD, `USBC_C_MODE_W);
      wr(`USBC_A_DATA, 8'h08);
      wait_for(0, 1'b1, 4);
      wait_for(1, 1'b0, 14);
      // Select wake enabled but no bus supply: ignored
      vbus <= 1'b0;
      csn <= 1'b0;
      repeat (20) @(posedge clk);
      chk(32'(susp), 32'h1);
      csn <= 1'b1;
      vbus <= 1'b1;
      idle_req <= 1'b0;
      wake <= 1'b1;
      wait_for(0, 1'b0, 40);
      chk(32'({kdrv, clocks_keep_running}), 32'h3);
      wake <= 1'b0;
      wait_for(2, 1'b0, 20);
      chk(32'(irq), 32'h1);
      apb(1'b0, `USBC_A_STAT, 8'h00, r, e);
      chk(r & 32'h3c, 32'h24);
      wr(`USBC_A_CMD, `USBC_C_INT_R);
      apb(1'b0, `USBC_A_DATA, 8'h00, r, e);
      chk(r & 32'hff, 32'h03);
      chk(32'(irq), 32'h0);
      wr(`USBC_A_CMD, `USBC_C_ADDR_W);
      wr(`USBC_A_DATA, 8'h11);
      chk(32'(dev_addr), 32'h85);
      wr(`USBC_A_CMD, `USBC_C_MODE_W);
      wr(`USBC_A_DATA, 8'h20);
      wr(`USBC_A_CMD, `USBC_C_UNLOCK);
      wr(`USBC_A_DATA, 8'h37);
      wr(`USBC_A_DATA, 8'haa);
      wr(`USBC_A_CMD, `USBC_C_ADDR_W);
      wr(`USBC_A_DATA, 8'h11);
      chk(32'(dev_addr), 32'h11);
      // Host resume: wake with no remote K of our own
      wr(`USBC_A_CMD, `USBC_C_MODE_W);
      wr(`USBC_A_DATA, 8'h20);
      wr(`USBC_A_CMD, `USBC_C_MODE_W);
      wr(`USBC_A_DATA, 8'h00);
      wait_for(0, 1'b1, 4);
      k_req <= 1'b1;
      wait_for(0, 1'b0, 60);
      chk(32'(kdrv), 32'h0);
      k_req <= 1'b0;
      wr(`USBC_A_CMD, `USBC_C_DEVRST);
      chk(32'(n_rst), 32'h1);
      chk(32'(dev_addr), 32'h0);
      stop_test;
   end
endmodule : testbench
